// *** rtl/hibs_params.svh ***
`ifndef HIBS_PARAMS_SVH
`define HIBS_PARAMS_SVH
// Strap encodings {data-out strap, interrupt strap}
`define HIBS_STRAP_I2C_LO 2'h0
`define HIBS_STRAP_I2C_HI 2'h2
`define HIBS_STRAP_SPI    2'h3
// I2C chip address pairs (write byte; read is write plus one)
`define HIBS_ADDR_LO_W    8'hC2
`define HIBS_ADDR_HI_W    8'hC8
// Reset values
`define HIBS_GPO_RST      1'h0
`define HIBS_IRQ_RST      1'h0
`endif

// *** rtl/hibs_pkg.sv ***
package hibs_pkg;
  // Latched host interface mode
  typedef enum logic [1:0] {
    HIBS_MODE_I2C_LO = 2'h0,
    HIBS_MODE_I2C_HI = 2'h1,
    HIBS_MODE_SPI    = 2'h3
  } hibs_mode_t;
  // Boot sequence states, Gray along the path
  typedef enum logic [1:0] {
    HIBS_ST_RESET = 2'h0,
    HIBS_ST_LATCH = 2'h1,
    HIBS_ST_RUN   = 2'h3
  } hibs_state_t;
endpackage : hibs_pkg

// *** rtl/hibs_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for a bus of pin levels
module hibs_sync #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         mclk,
  // Pin levels
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    meta_q <= din;
    dout   <= meta_q;
  end
endmodule : hibs_sync
`default_nettype wire

// *** rtl/hibs_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "hibs_params.svh"
// Contract
// RULE1: One host protocol, I2C or SPI, active, chosen at boot.
// RULE2: Straps sampled and latched on reset rising edge.
// RULE3: Held reset keeps device idle, no normal operation.
// RULE4: Host releases strap levels some time after reset release.
// RULE5: General output pin level set freely by software.
// RULE6: Radio data ready raises interrupt output to host.
// RULE7: Data pin is I2C SDA or SPI MOSI per mode.
// RULE8: Clock pin is I2C SCL or SPI clock per mode.
// RULE9: Host modifies parameters and reads quality and radio data.
// RULE10: High-level tuning and seek commands accepted over serial.
// RULE11: Debug mode pin tied to ground by board.
// RULE12: I2C answers address pair C2/C3 or C8/C9 per straps.
// RULE13: Straps 00 I2C low, 10 I2C high, 11 SPI.
// RULE14: Latched mode constant until next reset rising edge.
// RULE15: MISO undriven in I2C; in SPI driven only when selected.
module hibs_top
  import hibs_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Reset pin from host, asynchronous
  input  wire logic       reset_in_low_n,
  // Strap sense inputs (pads of the data-out and interrupt pins)
  input  wire logic       strap_miso_in,
  input  wire logic       strap_irq_in,
  // Shared serial pins
  input  wire logic       scl_clk_in,
  input  wire logic       sda_mosi_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       spi_cs_n_in,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_n,
  // Core protocol engine side
  input  wire logic       core_sda_pull,
  input  wire logic       core_miso_bit,
  input  wire logic       core_gpo_wr,
  input  wire logic       core_gpo_val,
  input  wire logic       core_radio_data_rdy,
  input  wire logic       core_radio_data_ack,
  // Debug pin, board keeps it grounded
  input  wire logic       debug_mode_in,
  // Results to the core
  output logic            core_run,
  output logic [1:0]      host_mode,
  output logic [7:0]      i2c_addr_w,
  output logic            i2c_sel,
  output logic            spi_sel,
  output logic            scl_core,
  output logic            sdi_core,
  // Pins to host
  output logic            general_output_pin,
  output logic            radio_data_irq
);
  // Synchronised pin levels and their named slices
  logic [4:0]  pin_s;
  logic        rst_pin_s;
  logic        rst_pin_q;
  logic        strap_do_s;
  logic        strap_irq_s;
  logic        scl_s;
  logic        sda_s;
  logic        cs_n_s;
  // Boot sequence state and the mode latched at the last pin rise
  hibs_state_t state_q;
  hibs_mode_t  mode_q;

  // Decode the strap pair into a mode; unused 01 falls back to low I2C
  function automatic hibs_mode_t hibs_decode(input logic [1:0] s);
    case (s)
      `HIBS_STRAP_I2C_HI: hibs_decode = HIBS_MODE_I2C_HI;
      `HIBS_STRAP_SPI:    hibs_decode = HIBS_MODE_SPI;
      default:            hibs_decode = HIBS_MODE_I2C_LO;
    endcase
  endfunction : hibs_decode

  // All pin inputs pass two flops before any logic
  hibs_sync #(.W(5)) u_sync (
    .mclk (mclk),
    .din  ({reset_in_low_n, strap_miso_in, strap_irq_in,
            scl_clk_in, sda_mosi_in}),
    .dout (pin_s)
  );
  assign rst_pin_s   = pin_s[4];
  assign strap_do_s  = pin_s[3];
  assign strap_irq_s = pin_s[2];
  assign scl_s       = pin_s[1];
  assign sda_s       = pin_s[0];

  // Chip select has its own pair to keep the bus width tidy
  hibs_sync #(.W(1)) u_sync_cs (
    .mclk (mclk),
    .din  (spi_cs_n_in),
    .dout (cs_n_s)
  );

  // Previous level of the reset pin for the rising edge.
  // Reset to the pin's running level: a core reset taken while the pin
  // is already high must not look like a fresh rise, or straps the host
  // has already let go would be latched as a new mode.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rst_pin_q <= 1'h1; // RULE2
    end else begin
      rst_pin_q <= rst_pin_s;
    end
  end

  // Boot sequence; pin low forces reset state at once
  // After a core reset the state waits here for a real pin rise
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= HIBS_ST_RESET;
    end else if (!rst_pin_s) begin
      state_q <= HIBS_ST_RESET; // RULE3
    end else begin
      case (state_q)
        HIBS_ST_RESET: if (!rst_pin_q) state_q <= HIBS_ST_LATCH;
        HIBS_ST_LATCH: state_q <= HIBS_ST_RUN;
        HIBS_ST_RUN:   state_q <= HIBS_ST_RUN;
        default:       state_q <= HIBS_ST_RESET;
      endcase
    end
  end

  // Straps caught only on the pin's rising edge, held otherwise.
  // Strap and reset share sync depth, so the level seen is the one
  // present when the pin rose, before the host lets the straps go.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      // Until the first pin rise the low-address I2C mode is assumed
      mode_q <= HIBS_MODE_I2C_LO;
    end else if (rst_pin_s && !rst_pin_q) begin
      mode_q <= hibs_decode({strap_do_s, strap_irq_s}); // RULE2 RULE13
    end
  end // RULE14 RULE1

  // Mode view for the protocol engine and address decode
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      core_run   <= 1'h0;
      host_mode  <= 2'h0;
      i2c_addr_w <= `HIBS_ADDR_LO_W;
      i2c_sel    <= 1'h0;
      spi_sel    <= 1'h0;
    end else begin
      core_run   <= (state_q == HIBS_ST_RUN) && rst_pin_s; // RULE3
      host_mode  <= mode_q;
      i2c_addr_w <= (mode_q == HIBS_MODE_I2C_HI) ?
                    `HIBS_ADDR_HI_W : `HIBS_ADDR_LO_W; // RULE12
      i2c_sel    <= (mode_q != HIBS_MODE_SPI); // RULE1
      // Select follows chip select three cycles late: two sync flops and this register
      spi_sel    <= (mode_q == HIBS_MODE_SPI) && !cs_n_s;
    end
  end

  // Shared pin routing; core engine handles RULE9 RULE10 commands
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_core <= 1'h1;
      sdi_core <= 1'h1;
    end else begin
      scl_core <= scl_s; // RULE8
      sdi_core <= sda_s; // RULE7
    end
  end

  // Data pin is open drain in I2C only; output stays low, enable pulls
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sda_out  <= 1'h0;
      sda_oe_n <= 1'h1;
    end else begin
      sda_out  <= 1'h0;
      sda_oe_n <= !(core_run && mode_q != HIBS_MODE_SPI &&
                    core_sda_pull); // RULE7
    end
  end

  // Data-out pin also carries a strap, so never driven before running
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      spi_miso_out  <= 1'h0;
      spi_miso_oe_n <= 1'h1;
    end else begin
      spi_miso_out  <= core_miso_bit;
      spi_miso_oe_n <= !(core_run && mode_q == HIBS_MODE_SPI &&
                         !cs_n_s); // RULE15
    end
  end

  // Software-set output level, kept low through reset
  // Cleared whenever not running, so a reboot starts from a known level
  always_ff @(posedge mclk) begin
    if (!resetn || !core_run) begin
      general_output_pin <= `HIBS_GPO_RST;
    end else if (core_gpo_wr) begin
      general_output_pin <= core_gpo_val; // RULE5
    end
  end

  // Interrupt: a new ready beats an ack in the same cycle
  // so data arriving as the host acks is never lost
  always_ff @(posedge mclk) begin
    if (!resetn || !core_run) begin
      radio_data_irq <= `HIBS_IRQ_RST;
    end else if (core_radio_data_rdy) begin
      radio_data_irq <= 1'h1; // RULE6
    end else if (core_radio_data_ack) begin
      radio_data_irq <= 1'h0;
    end
  end

  // Debug pin has no function here; RULE11 is the board's duty
  // Kept in a dummy net only so the pin is not left unread
  logic unused_ok;
  assign unused_ok = debug_mode_in;
endmodule : hibs_top
`default_nettype wire

// *** tb/hibs_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// Host side: reset pin and straps, straps let go after a hold
module hibs_host (
  input  wire logic       mclk, boot_req,
  input  wire logic [1:0] strap_sel,
  output logic            reset_in_low_n, debug_mode_in,
  output logic            strap_miso_in, strap_irq_in
);
  logic [2:0] hold_q = 3'h0;
  logic       drv;
  // Hold straps a few cycles past the pin rise, then let go
  always_ff @(posedge mclk) begin
    if (boot_req) hold_q <= 3'h0;
    else if (hold_q != 3'h6) hold_q <= hold_q + 3'h1;
  end
  // Released straps read as the pull-down level
  assign drv = boot_req | (hold_q != 3'h6);
  assign strap_miso_in = strap_sel[1] & drv;
  assign strap_irq_in = strap_sel[0] & drv;
  assign reset_in_low_n = !boot_req;
  assign debug_mode_in = 1'h0;
endmodule : hibs_host
`default_nettype wire

// *** tb/hibs_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
// Boot latch and pin sharing properties
module hibs_props (
  input wire logic       mclk, resetn, reset_in_low_n, spi_cs_n_in,
  input wire logic       core_gpo_wr, core_gpo_val, core_radio_data_rdy,
  input wire logic       core_run, i2c_sel, spi_miso_oe_n,
  input wire logic       general_output_pin, radio_data_irq,
  input wire logic [1:0] host_mode,
  input wire logic [7:0] i2c_addr_w
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Pin edges held long enough to cover the sync depth
  sequence s_rise;
    $rose(reset_in_low_n) ##1 reset_in_low_n [*5];
  endsequence
  sequence s_drop;
    $fell(reset_in_low_n) ##1 !reset_in_low_n [*4];
  endsequence
  a_boot_run_up: assert property (s_rise |-> ##[0:2] core_run)
    else $error("run late");
  a_reset_idle: assert property (s_drop |-> !core_run)
    else $error("run in reset");
  a_mode_held: assert property
    (core_run && $past(core_run) |-> $stable(host_mode))
    else $error("mode moved");
  a_mode_sel: assert property
    (core_run |-> i2c_sel == (host_mode != 2'h3))
    else $error("sel wrong");
  a_addr_pair: assert property
    (i2c_sel |-> i2c_addr_w == (host_mode[0] ? 8'hC8 : 8'hC2))
    else $error("addr wrong");
  a_miso_i2c_off: assert property (i2c_sel |-> spi_miso_oe_n)
    else $error("miso driven");
  a_miso_cs_off: assert property (spi_cs_n_in [*4] |-> spi_miso_oe_n)
    else $error("miso unselected");
  a_gpo_write: assert property
    (core_run && core_gpo_wr |=> general_output_pin == $past(core_gpo_val))
    else $error("gpo wrong");
  a_irq_raise: assert property
    (core_run && core_radio_data_rdy |=> radio_data_irq)
    else $error("irq missing");
  a_idle_clear: assert property
    (!core_run |=> !radio_data_irq && !general_output_pin)
    else $error("idle output set");
endmodule : hibs_props
bind hibs_top hibs_props i_hibs_props (.*);
`default_nettype wire

// *** tb/host_interface_boot_select_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
// Strap boot modes, shared pins and core side outputs
module host_interface_boot_select_bench;
  logic mclk, resetn, boot_req, scl_clk_in, sda_mosi_in, spi_cs_n_in;
  logic core_sda_pull, core_miso_bit, core_gpo_wr, core_gpo_val;
  logic core_radio_data_rdy, core_radio_data_ack, reset_in_low_n;
  logic strap_miso_in, strap_irq_in, debug_mode_in, sda_out, sda_oe_n;
  logic spi_miso_out, spi_miso_oe_n, core_run, i2c_sel, spi_sel;
  logic scl_core, sdi_core, general_output_pin, radio_data_irq;
  logic [1:0] strap_sel, host_mode;
  logic [7:0] i2c_addr_w;
  int   fails = 0, n_checks = 0, cyc = 0;
  hibs_top i_hibs_top (.*);
  hibs_host i_hibs_host (.*);
  // 25 MHz clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard, well past the roughly 135 cycles used
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask : step
  task automatic chk(input string s, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // Pulse the reset pin with straps set; mode must outlive the straps
  task automatic boot(input logic [1:0] s, m);
    int k = 0;
    boot_req = 1'b1;
    strap_sel = s;
    step(6);
    chk("run held", 8'h0, 8'(core_run));
    chk("gpo held", 8'h0, 8'(general_output_pin));
    chk("irq held", 8'h0, 8'(radio_data_irq));
    boot_req = 1'b0;
    while (core_run !== 1'b1 && k < 12) begin
      step(1);
      k++;
    end
    chk("run up", 8'h1, 8'(core_run));
    step(12);
    chk("mode", 8'(m), 8'(host_mode));
    chk("i2c", 8'(m != 2'h3), 8'(i2c_sel));
    if (m != 2'h3) chk("addr", m[0] ? 8'hC8 : 8'hC2, i2c_addr_w);
  endtask : boot
  // Data pull, clock and data paths, data-out enable by mode and select
  task automatic pins(input logic spi);
    {spi_cs_n_in, core_sda_pull, core_miso_bit} = 3'h3;
    {scl_clk_in, sda_mosi_in} = {2{spi}};
    step(5);
    chk("sda oe", 8'(spi), 8'(sda_oe_n));
    chk("sda out", 8'h0, 8'(sda_out));
    chk("miso oe", 8'(!spi), 8'(spi_miso_oe_n));
    chk("miso out", 8'h1, 8'(spi_miso_out));
    chk("spi sel", 8'(spi), 8'(spi_sel));
    chk("clk", 8'(spi), 8'(scl_core));
    chk("mosi", 8'(spi), 8'(sdi_core));
    spi_cs_n_in = 1'b1;
    step(5);
    chk("miso off", 8'h1, 8'(spi_miso_oe_n));
    chk("sel off", 8'h0, 8'(spi_sel));
  endtask : pins
  // Core reset with the reset pin high: no boot until the pin rises
  task automatic core_reset();
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    step(8);
    chk("no false boot", 8'h0, 8'(core_run));
  endtask : core_reset
  // General output write, interrupt raise and clear
  task automatic core_side();
    {core_gpo_val, core_gpo_wr, core_radio_data_rdy} = 3'h7;
    step(1);
    {core_gpo_wr, core_radio_data_rdy} = 2'h0;
    step(1);
    chk("gpo", 8'h1, 8'(general_output_pin));
    chk("irq", 8'h1, 8'(radio_data_irq));
    core_radio_data_ack = 1'b1;
    step(1);
    core_radio_data_ack = 1'b0;
    step(1);
    chk("irq clr", 8'h0, 8'(radio_data_irq));
  endtask : core_side
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Main sequence; strap 01 is expected to fall back to low address
  initial begin
    {resetn, boot_req, strap_sel, spi_cs_n_in, scl_clk_in} = 6'h13;
    {core_sda_pull, core_miso_bit, core_gpo_wr, core_gpo_val} = 4'h0;
    {sda_mosi_in, core_radio_data_rdy, core_radio_data_ack} = 3'h4;
    step(8);
    resetn = 1'b1;
    boot(2'h0, 2'h0);
    pins(1'b0);
    boot(2'h2, 2'h1);
    core_side();
    boot(2'h1, 2'h0);
    core_reset();
    boot(2'h3, 2'h3);
    pins(1'b1);
    end_of_test();
  end
endmodule : host_interface_boot_select_bench
`default_nettype wire
